// ### logic/teach_axis_map.svh
// Word offsets, bit positions and limits of the teaching and axis status area.
`ifndef TEACH_AXIS_MAP_SVH
`define TEACH_AXIS_MAP_SVH
`define OFS_TASK1_STATUS 6'h0F
`define OFS_TASK2_STATUS 6'h13
`define OFS_X_POS_LO 6'h14
`define OFS_X_POS_HI 6'h15
`define OFS_X_STATUS 6'h16
`define OFS_Y_POS_LO 6'h17
`define OFS_Y_POS_HI 6'h18
`define OFS_Y_STATUS 6'h19
`define BIT_TEACH_DONE 13
`define BIT_TEACH_ERR 14
`define BIT_TEACH_OVF 15
`define BIT_REF_ORIGIN 0
`define BIT_BUSY 1
`define BIT_SERVO_LOCKED 2
`define BIT_NO_ORIGIN 3
`define TEACH_ADDR_MAX 16'h07CF
`define POS_MIN 32'hFD9DA601
`define POS_MAX 32'h026259FF
`endif

// ### logic/teach_axis_pkg.sv
// Types shared by the teaching and axis status logic.
package teach_axis_pkg;
  typedef enum logic [3:0] {
    MAN_NONE,
    MAN_ORIGIN_SEARCH,
    MAN_ORIGIN_RETURN,
    MAN_JOG,
    MAN_ERR_CNT_RESET,
    MAN_POS_PRESET,
    MAN_ABSOLUTE_ORIGIN_SET,
    MAN_SERVO_LOCK,
    MAN_SERVO_UNLOCK,
    MAN_MANUAL_HANDWHEEL
  } man_cmd_t;
endpackage

// ### logic/motion_teach_axis_status.sv
// Teaching and axis status flags published in the host interface area.
// Functional notes
// - Teaching error sets error, completed, address-set flags.
// - Errors: no origin, address above 1999, or address plus axes out of range.
// - Error flag holds until next clean teaching or in-range command-area write.
// - Command-area teaching outside task range sets overflow.
// - Teaching bit checks address plus axes in range.
// - Normal teaching completion clears the overflow flag.
// - Overflow updates one exchange after command write.
// - Present position is clamped signed 32 bits.
// - Reference origin flag when origin reached in band.
// - Busy set while a manual command executes.
// - Busy clears only when control bit drops.
// - While busy, only servo unlock accepted.
// - Servo locked flag follows run command output.
// - Positioning without servo lock raises an error.
// - No-origin set on four origin-loss events.
// - Origin established on five events, flag clears.
// - Origin-requiring operation without origin is rejected.
// - Teaching completed set at end, cleared with bit.
`timescale 1ns/1ns
`include "teach_axis_map.svh"
module motion_teach_axis_status #(
  parameter int NTASK = 2,
  parameter int NAXIS = 2
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Host exchange: one pulse per scan, word read port.
  input wire logic exchange_in,
  input wire logic [5:0] rd_word_in,
  output logic [15:0] rd_data_out,
  // Teaching per task (request bit is task control word bit 09).
  input wire logic [NTASK-1:0] teach_req_in,
  input wire logic [NTASK-1:0] teach_cmd_wr_in,
  input wire logic [NTASK*16-1:0] teach_addr_in,
  input wire logic [NTASK*16-1:0] range_lo_in,
  input wire logic [NTASK*16-1:0] range_hi_in,
  input wire logic [NTASK*3-1:0] task_axes_in,
  // Per-axis state from the motion core.
  input wire logic [NAXIS*32-1:0] position_in,
  input wire logic [NAXIS-1:0] at_ref_origin_in,
  input wire logic [NAXIS-1:0] run_cmd_in,
  input wire logic [NAXIS*4-1:0] man_cmd_in,
  input wire logic [NAXIS-1:0] man_bit_in,
  input wire logic [NAXIS-1:0] pos_cmd_in,
  input wire logic [NAXIS-1:0] origin_op_in,
  input wire logic [NAXIS-1:0] origin_lost_in,
  input wire logic [NAXIS-1:0] origin_set_in,
  // Per-axis results, then the per-task address-set flags.
  output logic [NAXIS-1:0] man_accept_out,
  output logic [NAXIS-1:0] op_error_out,
  output logic [NAXIS-1:0] no_origin_out,
  output logic [NTASK-1:0] teach_addr_set_out
);
  // Only the two-task, two-axis word map is laid out in the decoder.
  if (NTASK != 2 || NAXIS != 2) begin : g_bad_size
    $error("Only the two-task, two-axis map is supported.");
  end

  // Per-task flags, gathered from the task blocks.
  wire [NTASK-1:0] done_q;
  wire [NTASK-1:0] err_q;
  wire [NTASK-1:0] ovf_q;
  wire [NTASK-1:0] addr_set_q;

  // Per-axis flags, gathered from the axis blocks.
  wire [NAXIS-1:0] busy_q;
  wire [NAXIS-1:0] noorg_q;
  wire [NAXIS-1:0] accept_q;
  wire [NAXIS-1:0] operr_q;

  // Published words and their next values.
  logic [15:0] task_word_q [NTASK];
  logic [15:0] axis_word_q [NAXIS];
  logic [31:0] pos_q [NAXIS];
  wire [15:0] task_word_d [NTASK];
  wire [15:0] axis_word_d [NAXIS];
  wire [31:0] pos_d [NAXIS];
  logic [15:0] rd_q;
  logic [15:0] rd_d;

  // Teaching needs an origin; it counts as present while any axis has one.
  wire any_origin;
  assign any_origin = !(&noorg_q);

  genvar g;
  generate
    for (g = 0; g < NTASK; g++) begin : g_task
      // Inputs of this task.
      wire [15:0] addr;
      wire [15:0] lo;
      wire [15:0] hi;
      wire [2:0] axes;
      wire [16:0] top;
      // Decoded events and checks.
      wire start;
      wire teach_bad;
      wire range_bad;
      wire cmd_bad;
      wire apply;
      // State of this task.
      logic req_prev_q;
      logic done_bit_q;
      logic set_bit_q;
      logic err_bit_q;
      logic ovf_bit_q;
      logic pend_q;
      logic pend_val_q;

      assign addr = teach_addr_in[g*16 +: 16];
      assign lo = range_lo_in[g*16 +: 16];
      assign hi = range_hi_in[g*16 +: 16];
      assign axes = task_axes_in[g*3 +: 3];
      assign top = {1'b0, addr} + {14'h0000, axes};
      assign start = teach_req_in[g] && !req_prev_q;
      assign teach_bad = !any_origin || addr > `TEACH_ADDR_MAX;
      assign range_bad = addr < lo || top > {1'b0, hi};
      assign cmd_bad = addr < lo || addr > hi;
      // A command-area result waits for the exchange after its write.
      assign apply = pend_q && exchange_in && !teach_cmd_wr_in[g];

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
          req_prev_q <= 1'b0;
        else
          req_prev_q <= teach_req_in[g];
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          done_bit_q <= 1'b0;
          set_bit_q <= 1'b0;
        end else if (start) begin
          done_bit_q <= 1'b1;
          set_bit_q <= 1'b1;
        end else if (!teach_req_in[g]) begin
          done_bit_q <= 1'b0;
          set_bit_q <= 1'b0;
        end
      end

      // A command-area result in the same cycle overrides a start's overflow; an in-range one also clears its error.
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          err_bit_q <= 1'b0;
          ovf_bit_q <= 1'b0;
        end else begin
          if (start) begin
            err_bit_q <= teach_bad || range_bad;
            ovf_bit_q <= range_bad;
          end
          if (apply) begin
            ovf_bit_q <= pend_val_q;
            if (!pend_val_q)
              err_bit_q <= 1'b0;
          end
        end
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          pend_q <= 1'b0;
          pend_val_q <= 1'b0;
        end else if (teach_cmd_wr_in[g]) begin
          pend_q <= 1'b1;
          pend_val_q <= cmd_bad;
        end else if (apply) begin
          pend_q <= 1'b0;
        end
      end

      assign done_q[g] = done_bit_q;
      assign err_q[g] = err_bit_q;
      assign ovf_q[g] = ovf_bit_q;
      assign addr_set_q[g] = set_bit_q;
      assign task_word_d[g] = (16'(done_bit_q) << `BIT_TEACH_DONE)
          | (16'(err_bit_q) << `BIT_TEACH_ERR)
          | (16'(ovf_bit_q) << `BIT_TEACH_OVF);
    end

    for (g = 0; g < NAXIS; g++) begin : g_axis
      // Inputs of this axis.
      wire signed [31:0] p;
      wire [3:0] cmd;
      // Decoded events and checks.
      wire man_valid;
      wire man_take;
      wire origin_need_bad;
      wire pos_bad;
      wire take;
      wire below;
      wire above;
      wire ref_bit;
      // State of this axis.
      logic busy_bit_q;
      logic noorg_bit_q;
      logic accept_bit_q;
      logic operr_bit_q;

      assign p = position_in[g*32 +: 32];
      assign cmd = man_cmd_in[g*4 +: 4];
      // A command runs only while its control bit is on.
      assign man_valid = man_bit_in[g]
          && cmd != 4'(teach_axis_pkg::MAN_NONE);
      assign man_take = man_valid && (!busy_bit_q
          || cmd == 4'(teach_axis_pkg::MAN_SERVO_UNLOCK));
      assign origin_need_bad = noorg_bit_q && (origin_op_in[g]
          || (man_valid
          && cmd == 4'(teach_axis_pkg::MAN_ORIGIN_RETURN)));
      assign take = man_take && !origin_need_bad;
      assign pos_bad = pos_cmd_in[g] && !run_cmd_in[g];
      assign below = p < $signed(`POS_MIN);
      assign above = p > $signed(`POS_MAX);
      assign pos_d[g] = below ? `POS_MIN : above ? `POS_MAX : p;
      assign ref_bit = at_ref_origin_in[g] && !noorg_bit_q;

      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          accept_bit_q <= 1'b0;
          operr_bit_q <= 1'b0;
        end else begin
          accept_bit_q <= take;
          operr_bit_q <= origin_need_bad || pos_bad;
        end
      end

      // A new command wins over a dropped control bit in one cycle.
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
          busy_bit_q <= 1'b0;
        else if (take)
          busy_bit_q <= 1'b1;
        else if (!man_bit_in[g])
          busy_bit_q <= 1'b0;
      end

      // Losing the origin wins over establishing it in one cycle.
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in)
          noorg_bit_q <= 1'b1;
        else if (origin_lost_in[g])
          noorg_bit_q <= 1'b1;
        else if (origin_set_in[g])
          noorg_bit_q <= 1'b0;
      end

      assign busy_q[g] = busy_bit_q;
      assign noorg_q[g] = noorg_bit_q;
      assign accept_q[g] = accept_bit_q;
      assign operr_q[g] = operr_bit_q;
      assign axis_word_d[g] = (16'(ref_bit) << `BIT_REF_ORIGIN)
          | (16'(busy_bit_q) << `BIT_BUSY)
          | (16'(run_cmd_in[g]) << `BIT_SERVO_LOCKED)
          | (16'(noorg_bit_q) << `BIT_NO_ORIGIN);
    end
  endgenerate

  // Snapshot every word on the exchange so that one word is coherent.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NTASK; i++)
        task_word_q[i] <= 16'h0000;
    end else if (exchange_in) begin
      for (int i = 0; i < NTASK; i++)
        task_word_q[i] <= task_word_d[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NAXIS; i++)
        axis_word_q[i] <= 16'h0000;
    end else if (exchange_in) begin
      for (int i = 0; i < NAXIS; i++)
        axis_word_q[i] <= axis_word_d[i];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NAXIS; i++)
        pos_q[i] <= 32'h00000000;
    end else if (exchange_in) begin
      for (int i = 0; i < NAXIS; i++)
        pos_q[i] <= pos_d[i];
    end
  end

  always_comb begin
    unique case (rd_word_in)
      `OFS_TASK1_STATUS: rd_d = task_word_q[0];
      `OFS_TASK2_STATUS: rd_d = task_word_q[1];
      `OFS_X_POS_LO: rd_d = pos_q[0][15:0];
      `OFS_X_POS_HI: rd_d = pos_q[0][31:16];
      `OFS_X_STATUS: rd_d = axis_word_q[0];
      `OFS_Y_POS_LO: rd_d = pos_q[1][15:0];
      `OFS_Y_POS_HI: rd_d = pos_q[1][31:16];
      `OFS_Y_STATUS: rd_d = axis_word_q[1];
      default: rd_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      rd_q <= 16'h0000;
    else
      rd_q <= rd_d;
  end

  assign rd_data_out = rd_q;
  assign man_accept_out = accept_q;
  assign op_error_out = operr_q;
  assign no_origin_out = noorg_q;
  assign teach_addr_set_out = addr_set_q;
endmodule

// ### bench/status_chk_sva.sv
// Concurrent checks on the teaching and axis status ports.
`timescale 1ns/1ns
`include "teach_axis_map.svh"
module status_chk #(parameter int NTASK = 2, parameter int NAXIS = 2) (
  input wire logic clk_in, rst_n_in, exchange_in,
  input wire logic [5:0] rd_word_in,
  input wire logic [15:0] rd_data_out,
  input wire logic [NTASK-1:0] teach_req_in, teach_addr_set_out,
  input wire logic [NAXIS*4-1:0] man_cmd_in,
  input wire logic [NAXIS-1:0] run_cmd_in, man_bit_in, pos_cmd_in,
  input wire logic [NAXIS-1:0] origin_op_in, origin_lost_in, origin_set_in,
  input wire logic [NAXIS-1:0] man_accept_out, op_error_out, no_origin_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_busy_x;
    man_accept_out[0] && man_bit_in[0] ##1 man_bit_in[0] &&
      man_cmd_in[3:0] != teach_axis_pkg::MAN_SERVO_UNLOCK;
  endsequence
  a_origin_lost: assert property (
    origin_lost_in[0] && !origin_set_in[0] |=> no_origin_out[0])
    else $error("no origin flag not set");
  a_origin_set: assert property (
    origin_set_in[1] && !origin_lost_in[1] |=> !no_origin_out[1])
    else $error("no origin flag not cleared");
  a_origin_needed: assert property (
    origin_op_in[0] && no_origin_out[0] && !origin_set_in[0]
    |=> op_error_out[0]) else $error("origin operation not rejected");
  a_unlocked_pos: assert property (
    pos_cmd_in[1] && !run_cmd_in[1] && $past(!run_cmd_in[1])
    |=> op_error_out[1]) else $error("positioning not rejected");
  a_busy_refuse: assert property (
    s_busy_x |=> !man_accept_out[0]) else $error("command taken while busy");
  a_pos_clamp: assert property (
    rd_word_in == `OFS_X_POS_HI |=> $signed(rd_data_out) >= $signed(16'hFD9D)
    && $signed(rd_data_out) <= $signed(16'h0262)) else $error("position range");
  a_words_stand: assert property (
    $stable(rd_word_in) && !exchange_in && !$past(exchange_in)
    |=> $stable(rd_data_out)) else $error("status word changed between scans");
  a_teach_err_set: assert property (
    $rose(teach_req_in[0]) && (&no_origin_out) |=> teach_addr_set_out[0])
    else $error("address setting flag not set on error");
endmodule
bind motion_teach_axis_status status_chk #(.NTASK(NTASK), .NAXIS(NAXIS)) chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .exchange_in(exchange_in),
  .rd_word_in(rd_word_in), .rd_data_out(rd_data_out),
  .teach_req_in(teach_req_in), .teach_addr_set_out(teach_addr_set_out),
  .man_cmd_in(man_cmd_in), .run_cmd_in(run_cmd_in), .man_bit_in(man_bit_in),
  .pos_cmd_in(pos_cmd_in), .origin_op_in(origin_op_in),
  .origin_lost_in(origin_lost_in), .origin_set_in(origin_set_in),
  .man_accept_out(man_accept_out), .op_error_out(op_error_out),
  .no_origin_out(no_origin_out));

// ### bench/host_plc_model.sv
// Host scan model: one exchange pulse per scan and word reads.
`timescale 1ns/1ns
module host_plc_model (
  input wire logic clk_in,
  input wire logic [15:0] data_in,
  output logic scan_out = 1'b0,
  output logic [5:0] word_out = 6'h00
);
  logic [2:0] scan_q = 3'h0;
  always @(posedge clk_in) begin
    scan_q <= scan_q + 3'h1;
    scan_out <= (scan_q == 3'h7);
  end
  // A read waits for a fresh exchange, so flags are sampled a scan later.
  task automatic read_word(input logic [5:0] idx, output logic [15:0] d);
    repeat (2) @(posedge clk_in);
    @(posedge clk_in iff scan_out);
    word_out <= idx;
    @(posedge clk_in);
    #1 d = data_in;
  endtask
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the teaching and axis status flags.
`timescale 1ns/1ns
`include "teach_axis_map.svh"
module tb_top;
  logic clk_in = 1'b0, rst_n_in = 1'b0, exchange_in;
  logic [5:0] rd_word_in, task_axes_in = 6'h12;
  logic [15:0] rd_data_out, d;
  logic [1:0] teach_req_in = 2'h0, teach_cmd_wr_in = 2'h0, run_cmd_in = 2'h0;
  logic [1:0] at_ref_origin_in = 2'h0, man_bit_in = 2'h0, pos_cmd_in = 2'h0;
  logic [1:0] origin_op_in = 2'h0, origin_lost_in = 2'h0, origin_set_in = 2'h0;
  logic [1:0] man_accept_out, op_error_out, no_origin_out, teach_addr_set_out;
  logic [31:0] teach_addr_in = 32'h0, range_lo_in = 32'h0;
  logic [31:0] range_hi_in = 32'h01000100;
  logic [63:0] position_in = 64'h0;
  logic [7:0] man_cmd_in = 8'h00;
  int mismatches = 0, samples_checked = 0;
  longint p;
  motion_teach_axis_status DUT (.*);
  host_plc_model host (.clk_in(clk_in), .data_in(rd_data_out),
    .scan_out(exchange_in), .word_out(rd_word_in));
  initial forever #2 clk_in = ~clk_in;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [5:0] w);
    host.read_word(w, d);
  endtask
  task automatic finish_test;
    $display("Checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    finish_test;
  end
  initial begin
    void'($urandom(32'h2D71222E));
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rd(6'h00);
    chk("unmapped", 16'h0000, d);
    rd(`OFS_X_STATUS);
    chk("x reset", 16'h0008, d);
    @(posedge clk_in) teach_req_in <= 2'h1;
    rd(`OFS_TASK1_STATUS);
    chk("teach no origin", 16'h6000, d & 16'hE000);
    chk("addr set", 16'h0001, {15'h0000, teach_addr_set_out[0]});
    @(posedge clk_in) origin_set_in <= 2'h3;
    @(posedge clk_in) origin_set_in <= 2'h0;
    @(posedge clk_in) teach_req_in <= 2'h0;
    rd(`OFS_TASK1_STATUS);
    chk("error held", 16'h4000, d & 16'hE000);
    chk("origin", 16'h0000, {14'h0, no_origin_out});
    @(posedge clk_in) begin
      teach_addr_in <= 32'h00FF0010;
      teach_req_in <= 2'h3;
    end
    rd(`OFS_TASK1_STATUS);
    chk("clean teach", 16'h2000, d & 16'hE000);
    rd(`OFS_TASK2_STATUS);
    chk("overflow", 16'hA000, d & 16'hA000);
    @(posedge clk_in) begin
      teach_addr_in[31:16] <= 16'h0020;
      teach_cmd_wr_in <= 2'h2;
    end
    @(posedge clk_in) teach_cmd_wr_in <= 2'h0;
    rd(`OFS_TASK2_STATUS);
    rd(`OFS_TASK2_STATUS);
    chk("overflow cleared", 16'h0000, d & 16'h8000);
    @(posedge clk_in) teach_req_in <= 2'h2;
    @(posedge clk_in) begin
      teach_addr_in[15:0] <= 16'h07D0 + 16'($urandom_range(0, 32'hF82F));
      teach_req_in <= 2'h3;
    end
    rd(`OFS_TASK1_STATUS);
    chk("address limit", 16'h4000, d & 16'h4000);
    $display("End of teaching test");
    for (int i = 0; i < 3; i++) begin
      p = (i == 0) ? -50000000 : (i == 1) ? 50000000 : $signed($urandom);
      @(posedge clk_in) position_in[31:0] <= p[31:0];
      if (p > 39999999) p = 39999999;
      if (p < -39999999) p = -39999999;
      rd(`OFS_X_POS_LO);
      chk("pos lo", p[15:0], d);
      rd(`OFS_X_POS_HI);
      chk("pos hi", p[31:16], d);
    end
    $display("End of position test");
    @(posedge clk_in) begin
      run_cmd_in <= 2'h1;
      at_ref_origin_in <= 2'h1;
      man_cmd_in[3:0] <= teach_axis_pkg::MAN_JOG;
      man_bit_in <= 2'h1;
      pos_cmd_in <= 2'h2;
    end
    @(posedge clk_in) pos_cmd_in <= 2'h0;
    @(posedge clk_in) man_cmd_in[3:0] <= teach_axis_pkg::MAN_ORIGIN_SEARCH;
    rd(`OFS_X_STATUS);
    chk("x busy", 16'h0007, d);
    @(posedge clk_in) man_bit_in <= 2'h0;
    @(posedge clk_in) origin_lost_in <= 2'h1;
    @(posedge clk_in) origin_lost_in <= 2'h0;
    @(posedge clk_in) origin_op_in <= 2'h1;
    @(posedge clk_in) origin_op_in <= 2'h0;
    rd(`OFS_X_STATUS);
    chk("x released", 16'h000C, d);
    $display("End of axis test");
    finish_test;
  end
endmodule
